// >>> common/cca_defs.vh
// constants of the call, jump, add and and-logic execution slice
// assumes inclusion by bare name from design files
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH
`define CCA_OP_ADD_REG 5'b00101
`define CCA_OP_ADD_DIR 8'h25
`define CCA_OP_ADD_IND 7'b0010011
`define CCA_OP_ADD_IMM 8'h24
`define CCA_OP_ADC_REG 5'b00111
`define CCA_OP_ADC_DIR 8'h35
`define CCA_OP_ADC_IND 7'b0011011
`define CCA_OP_ADC_IMM 8'h34
`define CCA_OP_AND_REG 5'b01011
`define CCA_OP_AND_DIR 8'h55
`define CCA_OP_AND_IND 7'b0101011
`define CCA_OP_AND_IMM 8'h54
`define CCA_OP_AND_DA 8'h52
`define CCA_OP_AND_DI 8'h53
`define CCA_OP_ANDC_BIT 8'h82
`define CCA_OP_ANDC_NBIT 8'hB0
`define CCA_OP_CALL_LO 5'b10001
`define CCA_OP_JUMP_LO 5'b00001
`define CCA_CLK_STD 4'hC
`define CCA_CLK_DBL 4'h6
`define CCA_PC_RST 16'h0000
`define CCA_SP_RST 8'h07
`define CCA_ACC_RST 8'h00
`define CCA_PORT_BASE 8'h80
`endif

// >>> hw/cca_core.v
// execution slice of an 8-bit core: absolute call/jump, add, add with carry, and-logic
// assumes program memory answers combinationally on code_addr; data ram is internal
// Overview of operation
// RULE1 - call: pc plus two, push low then high, stack pointer up two, flags kept
// RULE2 - call target: pc[15:11], opcode bits 7-5, second byte
// RULE3 - jump loads same in-block target, pushes nothing
// RULE4 - jump is two bytes: a10..a8 in opcode top bits, then 00001
// RULE5 - add sets carry from bit 7, auxiliary carry from bit 3, clears otherwise
// RULE6 - signed wrap flag is carry out of bit 6 xor carry out of bit 7
// RULE7 - add sources: register, direct, indirect, immediate; one machine cycle each
// RULE8 - add with carry adds acc, source and carry; same flag rules
// RULE9 - add with carry opcodes 35, 36/37, 34 hex
// RULE10 - byte and stores result, flags kept; acc and direct destinations
// RULE11 - and on a port reads the output latch, never the pins; only 52/53 read the latch here, and acc,direct (55) reads the pins
// RULE12 - and direct,#imm 53 hex three bytes; direct,acc 52 and acc,#imm 54
// RULE13 - carry and bit clears carry when source bit is 0; inverted form allowed
// RULE14 - carry and direct bit opcode 82 hex, two bytes, two cycles
// RULE15 - machine cycle lasts 12 clocks, or 6 in double-speed mode
// RULE16 - register forms use low three bits with bit 3 set; indirect uses bit 0
`timescale 1ns/1ns
`include "cca_defs.vh"
module cca_core (
    clk,
    rst_n,
    double_speed,
    code_addr,
    code_data,
    port_pins,
    port_latch,
    pc,
    acc,
    sp,
    carry,
    aux_carry,
    signed_wrap_flag,
    busy
);
    input wire clk;
    input wire rst_n;
    input wire double_speed;
    output reg [15:0] code_addr;
    input wire [7:0] code_data;
    input wire [7:0] port_pins;
    output reg [7:0] port_latch;
    output reg [15:0] pc;
    output reg [7:0] acc;
    output reg [7:0] sp;
    output reg carry;
    output reg aux_carry;
    output reg signed_wrap_flag;
    output reg busy;

    localparam ST_FETCH = 5'b00001;
    localparam ST_BYTE2 = 5'b00010;
    localparam ST_BYTE3 = 5'b00100;
    localparam ST_RDOP = 5'b01000;
    localparam ST_EXEC = 5'b10000;

    // pins feed plain reads of the port; read-modify-write forms use the latch
    reg [7:0] pin_s1_ff;
    reg [7:0] pin_s2_ff;
    reg [4:0] state_ff;
    reg [3:0] clk_cnt_ff;
    reg mcycle_ff;
    reg [7:0] op_ff;
    reg [7:0] b2_ff;
    reg [7:0] b3_ff;
    reg [1:0] push_ff;
    reg [7:0] ptr_ff;
    reg ptr_ok_ff;
    reg [7:0] ram_raddr;
    wire [7:0] ram_rdata;
    reg ram_we;
    reg [7:0] ram_waddr;
    reg [7:0] ram_wdata;
    reg [3:0] nxt_clk_cnt;
    wire tick;

    function [2:0] op_len;
        input [7:0] op;
        begin
            if (op == `CCA_OP_AND_DI)
                op_len = 3'd3; // RULE12
            else if (op[4:0] == `CCA_OP_CALL_LO || op[4:0] == `CCA_OP_JUMP_LO)
                op_len = 3'd2; // RULE4
            else if (op[3] || op[7:1] == `CCA_OP_ADD_IND || op[7:1] == `CCA_OP_ADC_IND
                    || op[7:1] == `CCA_OP_AND_IND)
                op_len = 3'd1; // RULE16
            else
                op_len = 3'd2; // RULE7
        end
    endfunction

    function is_port;
        input [7:0] a;
        begin
            is_port = (a == `CCA_PORT_BASE);
        end
    endfunction

    cca_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 8'h00;
            pin_s2_ff <= 8'h00;
        end else begin
            pin_s1_ff <= port_pins;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // machine-cycle prescaler; one tick per machine cycle
    always @* begin
        if (clk_cnt_ff >= (double_speed ? `CCA_CLK_DBL : `CCA_CLK_STD) - 4'h1)
            nxt_clk_cnt = 4'h0; // RULE15
        else
            nxt_clk_cnt = clk_cnt_ff + 4'h1;
    end
    assign tick = (clk_cnt_ff == 4'h0);

    // operand read address: register bank 0 or pointer contents or direct
    always @* begin
        ram_raddr = b2_ff;
        if (op_ff[3])
            ram_raddr = {5'h00, op_ff[2:0]}; // RULE16
        else if (op_ff[2:1] == 2'b11)
            ram_raddr = {7'h00, op_ff[0]};
        // pointer is held after its first read, or the read address would chase the data
        if (state_ff == ST_EXEC && op_ff[2:1] == 2'b11 && !op_ff[3])
            ram_raddr = ptr_ok_ff ? ptr_ff : ram_rdata;
    end

    wire [2:0] grp = op_ff[7:5];
    wire is_add_with_carry = (op_ff[7:4] == 4'h3); // RULE9
    wire is_add = (op_ff[7:4] == 4'h2) || is_add_with_carry;
    wire is_and = (op_ff[7:4] == 4'h5);
    // direct reads of the port see the synchronised pins
    wire [7:0] src = (op_ff[3:0] == 4'h4) ? b2_ff
        : ((op_ff[3:0] == 4'h5 && is_port(b2_ff)) ? pin_s2_ff : ram_rdata);
    wire cin = is_add_with_carry ? carry : 1'b0; // RULE8
    wire [4:0] lo = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    wire [7:0] lo7 = {1'b0, acc[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
    wire [8:0] sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
    // port destinations read the latch, not the pins
    wire [7:0] dir_old = is_port(b2_ff) ? port_latch : ram_rdata; // RULE11
    wire [15:0] pc2 = pc;
    wire [15:0] target = {pc2[15:11], grp, b2_ff}; // RULE2

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_FETCH;
            clk_cnt_ff <= 4'h0;
            mcycle_ff <= 1'b0;
            op_ff <= 8'h00;
            b2_ff <= 8'h00;
            b3_ff <= 8'h00;
            push_ff <= 2'b00;
            ptr_ff <= 8'h00;
            ptr_ok_ff <= 1'b0;
            pc <= `CCA_PC_RST;
            code_addr <= `CCA_PC_RST;
            acc <= `CCA_ACC_RST;
            sp <= `CCA_SP_RST;
            carry <= 1'b0;
            aux_carry <= 1'b0;
            signed_wrap_flag <= 1'b0;
            port_latch <= 8'hFF;
            busy <= 1'b0;
            ram_we <= 1'b0;
            ram_waddr <= 8'h00;
            ram_wdata <= 8'h00;
        end else begin
            clk_cnt_ff <= nxt_clk_cnt;
            ram_we <= 1'b0;
            case (state_ff)
                ST_FETCH: begin
                    // fetch in the clock after retire, so each form keeps its own machine cycles
                    busy <= 1'b1;
                    op_ff <= code_data;
                    pc <= pc + 16'h0001;
                    code_addr <= pc + 16'h0001;
                    mcycle_ff <= 1'b0;
                    state_ff <= (op_len(code_data) == 3'd1) ? ST_RDOP : ST_BYTE2; // RULE15
                end
                ST_BYTE2: begin
                    b2_ff <= code_data;
                    pc <= pc + 16'h0001; // RULE1
                    code_addr <= pc + 16'h0001;
                    state_ff <= (op_len(op_ff) == 3'd3) ? ST_BYTE3 : ST_RDOP;
                end
                ST_BYTE3: begin
                    b3_ff <= code_data;
                    pc <= pc + 16'h0001;
                    code_addr <= pc + 16'h0001;
                    state_ff <= ST_RDOP;
                end
                ST_RDOP: begin
                    state_ff <= ST_EXEC;
                    push_ff <= 2'b00;
                    ptr_ok_ff <= 1'b0;
                end
                ST_EXEC: begin
                    if (!ptr_ok_ff) begin
                        ptr_ff <= ram_rdata;
                        ptr_ok_ff <= 1'b1;
                    end
                    // two-cycle forms wait one more machine cycle before retiring
                    if (tick && (op_ff == `CCA_OP_AND_DI || op_ff == `CCA_OP_ANDC_BIT || op_ff == `CCA_OP_ANDC_NBIT
                            || op_ff[4:0] == `CCA_OP_CALL_LO || op_ff[4:0] == `CCA_OP_JUMP_LO) && !mcycle_ff) begin
                        mcycle_ff <= 1'b1; // RULE14
                    end else if (op_ff[4:0] == `CCA_OP_CALL_LO && push_ff != 2'b10) begin
                        push_ff <= push_ff + 2'b01;
                        sp <= sp + 8'h01; // RULE1
                        ram_we <= 1'b1;
                        ram_waddr <= sp + 8'h01;
                        ram_wdata <= (push_ff == 2'b00) ? pc[7:0] : pc[15:8];
                    end else if (tick) begin
                        state_ff <= ST_FETCH;
                        busy <= 1'b0;
                        if (op_ff[4:0] == `CCA_OP_CALL_LO || op_ff[4:0] == `CCA_OP_JUMP_LO) begin
                            pc <= target; // RULE3
                            code_addr <= target;
                        end else if (is_add && (op_ff[3] || op_ff[3:1] == 3'b011 || op_ff[3:1] == 3'b010)) begin
                            acc <= sum[7:0]; // RULE7
                            carry <= sum[8]; // RULE5
                            aux_carry <= lo[4];
                            signed_wrap_flag <= sum[8] ^ lo7[7]; // RULE6
                        end else if (is_and && op_ff == `CCA_OP_AND_DA) begin
                            ram_we <= !is_port(b2_ff); // RULE10
                            ram_waddr <= b2_ff;
                            ram_wdata <= dir_old & acc;
                            if (is_port(b2_ff))
                                port_latch <= port_latch & acc; // RULE11
                        end else if (is_and && op_ff == `CCA_OP_AND_DI) begin
                            ram_we <= !is_port(b2_ff); // RULE12
                            ram_waddr <= b2_ff;
                            ram_wdata <= dir_old & b3_ff;
                            if (is_port(b2_ff))
                                port_latch <= port_latch & b3_ff;
                        end else if (is_and) begin
                            acc <= acc & src; // RULE10
                        end else if (op_ff == `CCA_OP_ANDC_BIT || op_ff == `CCA_OP_ANDC_NBIT) begin
                            // bit address doubles as a byte address; low three bits pick the bit
                            if ((ram_rdata[b2_ff[2:0]] ^ (op_ff == `CCA_OP_ANDC_NBIT)) == 1'b0)
                                carry <= 1'b0; // RULE13
                        end
                    end
                end
                default: state_ff <= ST_FETCH;
            endcase
        end
    end
endmodule // cca_core

// >>> hw/cca_ram.v
// internal data ram of 256 bytes with registered read data
// assumes one read and one write port on the core clock
`timescale 1ns/1ns
module cca_ram (
    clk,
    we,
    waddr,
    wdata,
    raddr,
    rdata
);
    input wire clk;
    input wire we;
    input wire [7:0] waddr;
    input wire [7:0] wdata;
    input wire [7:0] raddr;
    output reg [7:0] rdata;
    reg [7:0] mem [0:255];
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // cca_ram

// >>> tb/cca_core_assertions.sv
// port checker for the execution slice core
// assumes binding onto cca_core, one clock domain
`timescale 1ns/1ns
module cca_checker (
    input wire clk,
    input wire rst_n,
    input wire double_speed,
    input wire [7:0] port_latch,
    input wire [15:0] pc,
    input wire [7:0] acc,
    input wire [7:0] sp,
    input wire carry,
    input wire aux_carry,
    input wire signed_wrap_flag
);
    wire [2:0] flags = {carry, aux_carry, signed_wrap_flag};
    reg [2:0] flags_ff;
    reg [7:0] gap_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= 3'h0;
            gap_ff <= 8'h00;
        end else begin
            flags_ff <= flags;
            gap_ff <= (flags != flags_ff) ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hFF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_reset_state;
        $rose(rst_n) |-> sp == 8'h07 && acc == 8'h00 && pc == 16'h0000 && port_latch == 8'hFF;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
    property p_sp_step;
        $changed(sp) |-> sp == $past(sp) + 8'h01 || sp == $past(sp) + 8'h02;
    endproperty
    a_sp_step: assert property (p_sp_step) else $error("stack pointer step wrong");
    property p_latch_clears;
        $changed(port_latch) |-> (port_latch & ~$past(port_latch)) == 8'h00;
    endproperty
    a_latch_clears: assert property (p_latch_clears) else $error("port latch bit set");
    property p_pc_block;
        $changed(pc[15:11]) |-> pc[15:11] == $past(pc[15:11]) + 5'h01;
    endproperty
    a_pc_block: assert property (p_pc_block) else $error("program counter left its block");
    property p_acc_hold_std;
        !double_speed && $changed(acc) |=> $stable(acc) [*8];
    endproperty
    a_acc_hold_std: assert property (p_acc_hold_std) else $error("acc changed within cycle");
    property p_acc_hold_dbl;
        double_speed && $changed(acc) |=> $stable(acc) [*4];
    endproperty
    a_acc_hold_dbl: assert property (p_acc_hold_dbl) else $error("acc changed too soon");
    property p_flag_gap;
        flags != flags_ff |-> gap_ff >= 8'h04;
    endproperty
    a_flag_gap: assert property (p_flag_gap) else $error("flags changed too soon");
    property p_latch_hold;
        $changed(port_latch) |=> $stable(port_latch) [*4];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("port latch unstable");
endmodule // cca_checker
bind cca_core cca_checker chk (.clk(clk), .rst_n(rst_n), .double_speed(double_speed),
    .port_latch(port_latch), .pc(pc), .acc(acc), .sp(sp), .carry(carry),
    .aux_carry(aux_carry), .signed_wrap_flag(signed_wrap_flag));

// >>> tb/cca_pmem.sv
// program memory model of 4K bytes, read without a clock
// assumes the bench loads mem before it restarts the core; at the first load the core is still held in reset
`timescale 1ns/1ns
module cca_pmem (
    input wire [15:0] code_addr,
    output wire [7:0] code_data
);
    reg [7:0] mem [0:4095];
    integer k;
    initial begin
        for (k = 0; k < 4096; k = k + 1)
            mem[k] = 8'h00;
    end
    // top address bits ignored, image repeats every 4K
    assign code_data = mem[code_addr[11:0]];
endmodule // cca_pmem

// >>> tb/cpu_call_add_and_exec_test.sv
// self-checking bench for the execution slice core
// assumes cca_pmem as program memory, bound checker
`timescale 1ns/1ns
module cpu_call_add_and_exec_test;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg double_speed = 1'b0;
    reg [7:0] port_pins = 8'h0F;
    wire [15:0] code_addr, pc;
    wire [7:0] code_data, port_latch, acc, sp;
    wire carry, aux_carry, signed_wrap_flag, busy;
    integer n_errors = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i;
    reg [55:0] rows [0:8];
    reg [55:0] r;
    always #10 clk = ~clk;
    cca_core uut (.clk(clk), .rst_n(rst_n), .double_speed(double_speed), .code_addr(code_addr),
        .code_data(code_data), .port_pins(port_pins), .port_latch(port_latch), .pc(pc), .acc(acc),
        .sp(sp), .carry(carry), .aux_carry(aux_carry), .signed_wrap_flag(signed_wrap_flag), .busy(busy));
    cca_pmem pmem (.code_addr(code_addr), .code_data(code_data));
    task check_byte(input [39:0] what, input [7:0] exp, input [7:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task check_addr(input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch address expected %h seen %h", exp, got);
            end
        end
    endtask
    task put3(input [15:0] a, input [23:0] b);
        begin
            pmem.mem[a[11:0]] = b[23:16];
            pmem.mem[a[11:0] + 12'h001] = b[15:8];
            pmem.mem[a[11:0] + 12'h002] = b[7:0];
        end
    endtask
    task restart(input ds);
        begin
            rst_n = 1'b0;
            double_speed = ds;
            repeat (16) @(posedge clk);
            #1;
            rst_n = 1'b1;
        end
    endtask
    task wait_addr(input [15:0] a);
        integer k;
        begin
            k = 0;
            while (code_addr !== a && k < 600) begin
                @(posedge clk);
                #1;
                k = k + 1;
            end
            check_addr(a, code_addr);
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            tally_and_finish;
        end
    end
    initial begin
        // a, b, op, operand, acc, {c,ac,ov}, double speed
        rows[0] = 56'hC3AA54FF6D0500;
        rows[1] = 56'hC3AA34016F0000;
        rows[2] = 56'h0F0154F0100200;
        rows[3] = 56'h7F013400800000;
        rows[4] = 56'h808034FF000601;
        rows[5] = 56'h01FF2520000000;
        rows[6] = 56'h01FF3520010000;
        rows[7] = 56'hFF01B020000600;
        rows[8] = 56'hFF018220000200;
        repeat (16) @(posedge clk);
        #2;
        check_byte("sp", 8'h07, sp);
        check_byte("latch", 8'hFF, port_latch);
        check_addr(16'h0000, pc);
        check_byte("busy", 8'h00, {7'h00, busy});
        $display("reset test done");
        for (i = 0; i < 9; i = i + 1) begin
            r = rows[i];
            // ram byte 20 cleared first, it feeds direct and bit sources
            put3(16'h0000, 24'h532000);
            put3(16'h0003, {8'h24, r[55:48], 8'h24});
            put3(16'h0006, r[47:24]);
            put3(16'h0009, 24'h010900);
            restart(r[0]);
            repeat (300) @(posedge clk);
            #1;
            check_byte("acc", r[23:16], acc);
            check_byte("flags", r[15:8], {5'h00, carry, aux_carry, signed_wrap_flag});
            $display("row %0d done", i);
        end
        put3(16'h0000, 24'h212300);
        put3(16'h0123, 24'h714500);
        put3(16'h0345, 24'h250925);
        put3(16'h0348, 24'h086149);
        restart(1'b0);
        wait_addr(16'h0345);
        repeat (300) @(posedge clk);
        #1;
        check_byte("sp", 8'h09, sp);
        check_byte("acc", 8'h26, acc);
        $display("call test done");
        put3(16'h0000, 24'hE1FE00);
        put3(16'h07FE, 24'h011000);
        put3(16'h0810, 24'h011000);
        restart(1'b0);
        @(posedge clk);
        #1;
        check_byte("busy", 8'h01, {7'h00, busy});
        // two two-cycle jumps: 24 clocks each from the first edge
        repeat (47) @(posedge clk);
        #1;
        check_addr(16'h0800, code_addr);
        @(posedge clk);
        #1;
        check_addr(16'h0810, code_addr);
        check_byte("busy", 8'h00, {7'h00, busy});
        wait_addr(16'h0810);
        check_byte("sp", 8'h07, sp);
        $display("jump test done");
        put3(16'h0000, 24'h538073);
        put3(16'h0003, 24'h243C52);
        put3(16'h0006, 24'h800107);
        restart(1'b0);
        repeat (300) @(posedge clk);
        #1;
        check_byte("latch", 8'h30, port_latch);
        check_byte("acc", 8'h3C, acc);
        $display("port test done");
        // r1 points at 30, r7 holds 4E; the last add reads the pins, not ram 80
        uut.u_ram.mem[8'h01] = 8'h30;
        uut.u_ram.mem[8'h07] = 8'h4E;
        uut.u_ram.mem[8'h30] = 8'h5A;
        put3(16'h0000, 24'h272F57);
        put3(16'h0003, 24'h5F3752);
        put3(16'h0006, 24'h302530);
        put3(16'h0009, 24'h258001);
        put3(16'h000C, 24'h0B0000);
        restart(1'b0);
        repeat (300) @(posedge clk);
        #1;
        check_byte("acc", 8'hB3, acc);
        check_byte("flags", 8'h02, {5'h00, carry, aux_carry, signed_wrap_flag});
        $display("register test done");
        tally_and_finish;
    end
endmodule // cpu_call_add_and_exec_test
